// file: src/tmc_pkg.sv
// types for the touch measure control block
package tmc_pkg;
    typedef enum logic [1:0] {
        TMC_IDLE = 2'b00,
        TMC_CMD  = 2'b01,
        TMC_CONV = 2'b10
    } tmc_state_t;
    // analog input selection
    typedef enum logic [2:0] {
        TMC_IN_NONE  = 3'b000,
        TMC_IN_XP    = 3'b001,
        TMC_IN_YP    = 3'b010,
        TMC_IN_YN    = 3'b011,
        TMC_IN_BAT   = 3'b100,
        TMC_IN_AUX   = 3'b101,
        TMC_IN_TEMP  = 3'b110
    } tmc_in_t;
    // reference source selection
    typedef enum logic [1:0] {
        TMC_REF_PIN  = 2'b00,
        TMC_REF_YP   = 2'b01,
        TMC_REF_XP   = 2'b10
    } tmc_refp_t;
    typedef enum logic [1:0] {
        TMC_REFN_GND = 2'b00,
        TMC_REFN_YN  = 2'b01,
        TMC_REFN_XN  = 2'b10
    } tmc_refn_t;
endpackage

// file: src/tmc_regs.svh
// constants for the touch measure control block
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_BIT_START    7
`define TMC_BIT_ADDR_HI  6
`define TMC_BIT_ADDR_LO  4
`define TMC_BIT_RES      3
`define TMC_BIT_REFMODE  2
`define TMC_BIT_REFPWR   1
`define TMC_BIT_ADCPWR   0
`define TMC_CH_TEMP_BASE_BIAS_POINT     3'h0
`define TMC_CH_YPOS      3'h1
`define TMC_CH_BAT       3'h2
`define TMC_CH_Z1        3'h3
`define TMC_CH_Z2        3'h4
`define TMC_CH_XPOS      3'h5
`define TMC_CH_AUX       3'h6
`define TMC_CH_TEMP_SCALED_BIAS_POINT     3'h7
`define TMC_ACQ_FIRST    5'h05
`define TMC_ACQ_LAST     5'h08
`define TMC_RES12_BITS   5'h0c
`define TMC_RES8_BITS    5'h08
`endif

// file: src/tmc_touch_measure_control.sv
// measurement control: control byte decode, plate drivers, references, pen interrupt
// Operation
// - reference-mode bit 1 gives single-ended, 0 gives differential conversion
// - single-ended Y: X+ to input, Y drivers on, reference pin and ground
// - single-ended: plate bias removed once acquisition ends
// - differential Y: positive reference Y+, negative reference Y-
// - differential: plate drivers on through acquisition and whole conversion
// - enabled pen interrupt output goes low while the screen is touched
// - pen interrupt valid again after last result bit or chip select high
// - address zero converts diode at base bias current
// - address all ones converts diode at scaled bias current
// - battery divider enabled only while battery channel is sampled
// - reference power bit 1 enables internal reference
// - internal reference used for single-ended, battery, temperature, auxiliary
// - temperature conversions always use internal reference
// - pen interrupt enabled only when both power bits are 0
// - control byte: start 7, address 6..4, resolution 3, mode 2, power 1..0
`timescale 1ns/10ps
`include "tmc_regs.svh"

module tmc_touch_measure_control
    import tmc_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       serial_clk_i,
    input  wire logic       chip_sel_n_i,
    input  wire logic       serial_din_i,
    input  wire logic       touch_detect_i,
    output logic            pen_touch_irq_n_o,
    output logic            pen_irq_valid_o,
    output logic            xp_drive_o,
    output logic            xn_drive_o,
    output logic            yp_drive_o,
    output logic            yn_drive_o,
    output logic [2:0]      adc_input_sel_o,
    output logic [1:0]      ref_pos_sel_o,
    output logic [1:0]      ref_neg_sel_o,
    output logic            int_ref_enable_o,
    output logic            battery_div_en_o,
    output logic            temp_base_bias_point_o,
    output logic            temp_scaled_bias_point_o,
    output logic            res_8bit_o,
    output logic            busy_o
);

    // control byte address field decoded once, called only by the field latch
    function automatic logic [2:0] chan_of(input logic [7:0] b);
        chan_of = b[`TMC_BIT_ADDR_HI:`TMC_BIT_ADDR_LO];
    endfunction

    // two-flop synchronisers; first stage read only by second
    logic [1:0] sclk_s_q, cs_s_q, din_s_q, touch_s_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sclk_s_q  <= 2'h0;
            cs_s_q    <= 2'h3;
            din_s_q   <= 2'h0;
            touch_s_q <= 2'h0;
        end
        else
        begin
            sclk_s_q  <= {sclk_s_q[0], serial_clk_i};
            cs_s_q    <= {cs_s_q[0], chip_sel_n_i};
            din_s_q   <= {din_s_q[0], serial_din_i};
            touch_s_q <= {touch_s_q[0], touch_detect_i};
        end
    end

    // edge detection on the synchronised serial clock
    logic sclk_prev_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s_q[1];
    end
    logic rise, fall, cs_low;
    assign rise   = sclk_s_q[1] & ~sclk_prev_q;
    assign fall   = ~sclk_s_q[1] & sclk_prev_q;
    assign cs_low = ~cs_s_q[1];

    // frame sequencing: hunt for start bit, shift byte, count conversion falls
    tmc_state_t state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [4:0] fall_cnt_q;
    logic [4:0] conv_len_q;
    logic       byte_done_q;
    logic       last_bit_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q     <= TMC_IDLE;
            shift_q     <= 8'h00;
            bit_cnt_q   <= 3'h0;
            fall_cnt_q  <= 5'h00;
            conv_len_q  <= `TMC_RES12_BITS;
            byte_done_q <= 1'b0;
            last_bit_q  <= 1'b0;
        end
        else
        begin
            byte_done_q <= 1'b0;
            last_bit_q  <= 1'b0;
            if (!cs_low)
            begin
                // chip select high aborts everything; selections stay put
                state_q    <= TMC_IDLE;
                bit_cnt_q  <= 3'h0;
                fall_cnt_q <= 5'h00;
            end
            else
            begin
                case (state_q)
                    TMC_IDLE:
                    begin
                        // zeros before the start bit have no effect
                        if (rise && din_s_q[1])
                        begin
                            shift_q   <= 8'h01;
                            bit_cnt_q <= 3'h1;
                            state_q   <= TMC_CMD;
                        end
                    end
                    TMC_CMD:
                    begin
                        if (rise)
                        begin
                            shift_q   <= {shift_q[6:0], din_s_q[1]};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == 3'h7)
                            begin
                                byte_done_q <= 1'b1;
                                fall_cnt_q  <= 5'h00;
                                conv_len_q  <= shift_q[`TMC_BIT_RES - 1] ? `TMC_RES8_BITS : `TMC_RES12_BITS;
                                state_q     <= TMC_CONV;
                            end
                        end
                    end
                    TMC_CONV:
                    begin
                        // fall 1 is busy, then one result bit per fall
                        if (fall)
                        begin
                            fall_cnt_q <= fall_cnt_q + 5'h01;
                            if (fall_cnt_q == conv_len_q)
                            begin
                                last_bit_q <= 1'b1;
                                state_q    <= TMC_IDLE;
                                bit_cnt_q  <= 3'h0;
                            end
                        end
                    end
                    default: state_q <= TMC_IDLE;
                endcase
            end
        end
    end

    // acquisition spans control falls 5..8; here held from fall 4 up to fall 8 of the byte
    logic [4:0] cmd_fall_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            cmd_fall_q <= 5'h00;
        else if (!cs_low || state_q == TMC_IDLE)
            cmd_fall_q <= 5'h00;
        else if (fall && cmd_fall_q != 5'h1f)
            cmd_fall_q <= cmd_fall_q + 5'h01;
    end
    logic acquiring;
    assign acquiring = (state_q != TMC_IDLE) && cmd_fall_q >= `TMC_ACQ_FIRST - 5'h01
                       && cmd_fall_q < `TMC_ACQ_LAST;

    // latched control byte fields from last accepted byte
    logic [2:0] chan_q;
    logic       single_q, ref_pwr_q, adc_pwr_q, res8_q;
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            chan_q    <= 3'h0;
            single_q  <= 1'b0;
            ref_pwr_q <= 1'b0;
            adc_pwr_q <= 1'b0;
            res8_q    <= 1'b0;
        end
        else if (byte_done_q)
        begin
            chan_q    <= chan_of(shift_q);
            single_q  <= shift_q[`TMC_BIT_REFMODE];
            ref_pwr_q <= shift_q[`TMC_BIT_REFPWR];
            adc_pwr_q <= shift_q[`TMC_BIT_ADCPWR];
            res8_q    <= shift_q[`TMC_BIT_RES];
        end
    end

    // plate drivers; single-ended drops bias after acquisition, differential holds it
    logic active, drv_on;
    assign active = (state_q == TMC_CONV) || acquiring;
    assign drv_on = single_q ? acquiring : active;
    logic [3:0] drv_d;
    always_comb
    begin
        drv_d = 4'h0;
        case (chan_q)
            `TMC_CH_YPOS: drv_d = 4'b0011;
            `TMC_CH_Z1:   drv_d = 4'b0110; // pressure: X- and Y+ drivers
            `TMC_CH_Z2:   drv_d = 4'b0110;
            `TMC_CH_XPOS: drv_d = 4'b1100;
            default:      drv_d = 4'h0;
        endcase
    end

    // analog input and reference routing, held between bytes
    tmc_in_t   in_d;
    tmc_refp_t rp_d;
    tmc_refn_t rn_d;
    always_comb
    begin
        in_d = TMC_IN_NONE;
        rp_d = TMC_REF_PIN;
        rn_d = TMC_REFN_GND;
        case (chan_q)
            `TMC_CH_TEMP_BASE_BIAS_POINT, `TMC_CH_TEMP_SCALED_BIAS_POINT: in_d = TMC_IN_TEMP;
            `TMC_CH_YPOS: in_d = TMC_IN_XP;
            `TMC_CH_BAT:  in_d = TMC_IN_BAT;
            `TMC_CH_Z1:   in_d = TMC_IN_XP;
            `TMC_CH_Z2:   in_d = TMC_IN_YN;
            `TMC_CH_XPOS: in_d = TMC_IN_YP;
            `TMC_CH_AUX:  in_d = TMC_IN_AUX;
            default:      in_d = TMC_IN_NONE;
        endcase
        if (!single_q)
        begin
            case (chan_q)
                `TMC_CH_YPOS:
                begin
                    rp_d = TMC_REF_YP;
                    rn_d = TMC_REFN_YN;
                end
                `TMC_CH_Z1, `TMC_CH_Z2:
                begin
                    rp_d = TMC_REF_YP;
                    rn_d = TMC_REFN_XN;
                end
                `TMC_CH_XPOS:
                begin
                    rp_d = TMC_REF_XP;
                    rn_d = TMC_REFN_XN;
                end
                default:
                begin
                    rp_d = TMC_REF_PIN;
                    rn_d = TMC_REFN_GND;
                end
            endcase
        end
    end

    // pen interrupt: enabled only in power mode 00; valid flag low during a frame
    logic pen_en, is_temp, frame_q;
    assign pen_en  = ~ref_pwr_q & ~adc_pwr_q;
    assign is_temp = (chan_q == `TMC_CH_TEMP_BASE_BIAS_POINT) || (chan_q == `TMC_CH_TEMP_SCALED_BIAS_POINT);
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            frame_q <= 1'b0;
        else if (!cs_low || last_bit_q)
            frame_q <= 1'b0;
        else if (state_q != TMC_IDLE)
            frame_q <= 1'b1;
    end

    // all outputs registered
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pen_touch_irq_n_o        <= 1'b1;
            pen_irq_valid_o          <= 1'b1;
            {xp_drive_o, xn_drive_o, yp_drive_o, yn_drive_o} <= 4'h0;
            adc_input_sel_o          <= 3'h0;
            ref_pos_sel_o            <= 2'h0;
            ref_neg_sel_o            <= 2'h0;
            int_ref_enable_o         <= 1'b0;
            battery_div_en_o         <= 1'b0;
            temp_base_bias_point_o   <= 1'b0;
            temp_scaled_bias_point_o <= 1'b0;
            res_8bit_o               <= 1'b0;
            busy_o                   <= 1'b0;
        end
        else
        begin
            pen_touch_irq_n_o <= ~(pen_en & touch_s_q[1]);
            pen_irq_valid_o   <= ~frame_q;
            {xp_drive_o, xn_drive_o, yp_drive_o, yn_drive_o} <= drv_on ? drv_d : 4'h0;
            adc_input_sel_o   <= in_d;
            ref_pos_sel_o     <= rp_d;
            ref_neg_sel_o     <= rn_d;
            int_ref_enable_o  <= ref_pwr_q | (is_temp & active);
            battery_div_en_o  <= (chan_q == `TMC_CH_BAT) && acquiring;
            temp_base_bias_point_o   <= (chan_q == `TMC_CH_TEMP_BASE_BIAS_POINT) && active;
            temp_scaled_bias_point_o <= (chan_q == `TMC_CH_TEMP_SCALED_BIAS_POINT) && active;
            res_8bit_o        <= res8_q;
            busy_o            <= (state_q == TMC_CONV) && (fall_cnt_q == 5'h00);
        end
    end

    // checks
    a_bat_div_gate: assert property (@(posedge clock_i) disable iff (rst_i)
        battery_div_en_o |-> $past(chan_q) == `TMC_CH_BAT)
        else $error("battery divider on outside battery channel");
    a_pen_mask_power: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(ref_pwr_q | adc_pwr_q) |-> pen_touch_irq_n_o)
        else $error("pen interrupt active while disabled");
    a_pen_touch_low: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(pen_en) && $past(touch_s_q[1])) |-> !pen_touch_irq_n_o)
        else $error("pen interrupt not low on touch");
    a_pen_valid_cs: assert property (@(posedge clock_i) disable iff (rst_i)
        !cs_low |-> ##2 pen_irq_valid_o)
        else $error("pen interrupt not valid after chip select high");
    a_hold_fields: assert property (@(posedge clock_i) disable iff (rst_i)
        !$past(byte_done_q) |-> $stable(chan_q) && $stable(single_q))
        else $error("selection changed without new byte");
    a_diff_ref_y: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(!single_q) && $past(chan_q) == `TMC_CH_YPOS) |-> ref_pos_sel_o == TMC_REF_YP
        && ref_neg_sel_o == TMC_REFN_YN)
        else $error("differential Y reference wrong");
    a_se_drv_off: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(single_q) && !$past(acquiring)) |-> !(yp_drive_o | yn_drive_o | xp_drive_o | xn_drive_o))
        else $error("single-ended bias during decisions");
    a_diff_drv_on: assert property (@(posedge clock_i) disable iff (rst_i)
        ($past(!single_q) && $past(state_q) == TMC_CONV && $past(chan_q) == `TMC_CH_YPOS)
        |-> yp_drive_o && yn_drive_o)
        else $error("differential drivers dropped during conversion");
    a_ref_enable: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(ref_pwr_q) |-> int_ref_enable_o)
        else $error("internal reference not enabled");

endmodule

// file: verification/tmc_host_model.sv
// host model: drives control frames on the serial pins and answers the pen interrupt
`timescale 1ns/10ps

module tmc_host_model (
    input  wire logic clock_i,
    input  wire logic pen_touch_irq_n_i,
    output logic      serial_clk_o,
    output logic      chip_sel_n_o,
    output logic      serial_din_o
);
    int fall_n;

    // serial clock parks low between frames, it never runs free
    initial
    begin
        serial_clk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_din_o = 1'b1;
        fall_n       = 0;
    end

    // pins change a fixed 2 ns after the system clock edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    // control byte msb first, then zeros while results clock out; short n_bits aborts the frame
    task automatic frame(input logic [7:0] ctl, input int n_bits, input int hold);
        int k;
        fall_n = 0;
        wait_clk(4);
        chip_sel_n_o = 1'b0;
        for (k = 0; k < n_bits; k++)
        begin
            serial_din_o = (k < 8) ? ctl[7-k] : 1'b0;
            wait_clk(4);
            serial_clk_o = 1'b1;
            wait_clk(4);
            serial_clk_o = 1'b0;
            fall_n = k + 1;
        end
        wait_clk(hold);
        chip_sel_n_o = 1'b1;
        serial_din_o = ~serial_din_o; // released line shows no stale value
    endtask

    // pen interrupt only looked at before chip select falls, never during the frame
    task automatic answer_irq(input logic [7:0] ctl, output logic seen);
        int t;
        seen = 1'b0;
        for (t = 0; t < 50 && !seen; t++)
        begin
            @(posedge clock_i);
            #1;
            seen = (pen_touch_irq_n_i === 1'b0);
        end
        if (seen)
            frame(ctl, 21, 4);
    endtask
endmodule

// file: verification/touch_measure_control_test.sv
// testbench for the touch measure control block against the host model
`timescale 1ns/10ps
`include "tmc_regs.svh"

module touch_measure_control_test;
    import tmc_pkg::*;
    logic       clock_i = 1'b0;
    logic       rst_i   = 1'b1;
    logic       touch   = 1'b0;
    wire        sclk;
    wire        cs_n;
    wire        din;
    logic       irq_n, pen_valid, xp, xn, yp, yn, iref, bdiv, tb0, tb1, r8, busy;
    logic [2:0] sel;
    logic [1:0] refp, refn;
    logic       seen;
    int         n_mismatch   = 0;
    int         total_checks = 0;

    always #20 clock_i = ~clock_i;

    tmc_host_model host_i (.clock_i(clock_i), .pen_touch_irq_n_i(irq_n), .serial_clk_o(sclk),
        .chip_sel_n_o(cs_n), .serial_din_o(din));

    tmc_touch_measure_control tmc_touch_measure_control_i (.clock_i(clock_i), .rst_i(rst_i),
        .serial_clk_i(sclk), .chip_sel_n_i(cs_n), .serial_din_i(din), .touch_detect_i(touch),
        .pen_touch_irq_n_o(irq_n), .pen_irq_valid_o(pen_valid), .xp_drive_o(xp), .xn_drive_o(xn),
        .yp_drive_o(yp), .yn_drive_o(yn), .adc_input_sel_o(sel), .ref_pos_sel_o(refp),
        .ref_neg_sel_o(refn), .int_ref_enable_o(iref), .battery_div_en_o(bdiv),
        .temp_base_bias_point_o(tb0), .temp_scaled_bias_point_o(tb1), .res_8bit_o(r8), .busy_o(busy));

    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] ctl(input logic [2:0] ch, input logic res, input logic ser,
        input logic [1:0] pd);
        return {1'b1, ch, res, ser, pd};
    endfunction

    // bounded wait for a serial fall, then let the decode settle
    task automatic at_fall(input int n, input int d);
        int t;
        for (t = 0; t < 400 && host_i.fall_n != n; t++)
            @(posedge clock_i);
        // a stalled frame counts as a failure, not a silent pass
        if (host_i.fall_n != n)
        begin
            n_mismatch++;
            $display("mismatch serial fall expected %0d seen %0d", n, host_i.fall_n);
        end
        repeat (d) @(posedge clock_i);
        #5;
    endtask

    // single-ended y: drivers only in acquisition, pen valid back at last bit
    task automatic t_single_y();
        fork
            host_i.frame(ctl(`TMC_CH_YPOS, 1'b0, 1'b1, 2'b00), 21, 20);
            begin
                // new selection meets acquisition only between byte latch and fall 8
                at_fall(8, 1);
                chk("se drv acq", 4'h3, {xp, xn, yp, yn});
                chk("busy start", 4'h1, 4'(busy));
                chk("se sel", 4'(TMC_IN_XP), 4'(sel));
                chk("se refs", 4'h0, {refp, refn});
                at_fall(14, 6);
                chk("se drv conv", 4'h0, {xp, xn, yp, yn});
                chk("busy end", 4'h0, 4'(busy));
                chk("valid in frame", 4'h0, 4'(pen_valid));
                at_fall(21, 12);
                chk("valid last bit", 4'h1, 4'(pen_valid));
            end
        join
        wait_settle();
        chk("se sel held", 4'(TMC_IN_XP), 4'(sel));
    endtask

    // differential y: ratiometric references, drivers stay on in conversion
    task automatic t_diff_y();
        fork
            host_i.frame(ctl(`TMC_CH_YPOS, 1'b0, 1'b0, 2'b00), 21, 4);
            begin
                at_fall(14, 6);
                chk("df drv conv", 4'h3, {xp, xn, yp, yn});
                chk("df refs", {2'(TMC_REF_YP), 2'(TMC_REFN_YN)}, {refp, refn});
            end
        join
    endtask

    // differential pressure point: Y+ and X- driven through the conversion
    task automatic t_z1();
        fork
            host_i.frame(ctl(`TMC_CH_Z1, 1'b0, 1'b0, 2'b00), 21, 4);
            begin
                at_fall(14, 6);
                chk("z1 drv conv", 4'h6, {xp, xn, yp, yn});
                chk("z1 refs", {2'(TMC_REF_YP), 2'(TMC_REFN_XN)}, {refp, refn});
            end
        join
    endtask

    // battery with reference power, then aborted frame keeps the old selection
    task automatic t_battery();
        fork
            // no result is read here, so the reference settling wait is not held
            host_i.frame(ctl(`TMC_CH_BAT, 1'b0, 1'b1, 2'b10), 21, 4);
            begin
                at_fall(8, 1);
                chk("bat div", 4'h1, 4'(bdiv));
                chk("bat sel", 4'(TMC_IN_BAT), 4'(sel));
                chk("iref on", 4'h1, 4'(iref));
            end
        join
        wait_settle();
        chk("bat div off", 4'h0, 4'(bdiv));
        host_i.frame(ctl(`TMC_CH_AUX, 1'b0, 1'b1, 2'b00), 5, 4);
        wait_settle();
        chk("abort sel", 4'(TMC_IN_BAT), 4'(sel));
        chk("abort valid", 4'h1, 4'(pen_valid));
        chk("abort iref", 4'h1, 4'(iref));
        host_i.frame(ctl(`TMC_CH_AUX, 1'b0, 1'b1, 2'b00), 21, 4);
        wait_settle();
        chk("iref off", 4'h0, 4'(iref));
    endtask

    // temperature points: diode bias and internal reference without reference power
    task automatic t_temp(input logic [2:0] ch, input logic res, input int n_bits);
        fork
            host_i.frame(ctl(ch, res, 1'b1, 2'b00), n_bits, 4);
            begin
                at_fall(8, 6);
                chk("temp bias", {2'h0, ch == `TMC_CH_TEMP_SCALED_BIAS_POINT, ch == `TMC_CH_TEMP_BASE_BIAS_POINT}, {2'h0, tb1, tb0});
                chk("temp sel", 4'(TMC_IN_TEMP), 4'(sel));
                chk("temp iref", 4'h1, 4'(iref));
            end
        join
        wait_settle();
        chk("res bit", 4'(res), 4'(r8));
    endtask

    // pen interrupt answered, then masked by power bits 01
    task automatic t_pen();
        @(posedge clock_i);
        #2 touch = 1'b1;
        host_i.answer_irq(ctl(`TMC_CH_XPOS, 1'b0, 1'b0, 2'b01), seen);
        chk("irq seen", 4'h1, 4'(seen));
        wait_settle();
        chk("irq masked", 4'h1, 4'(irq_n));
        chk("dfx refs", {2'(TMC_REF_XP), 2'(TMC_REFN_XN)}, {refp, refn});
        chk("dfx sel", 4'(TMC_IN_YP), 4'(sel));
        @(posedge clock_i);
        #2 touch = 1'b0;
    endtask

    task automatic wait_settle();
        repeat (10) @(posedge clock_i);
        #5;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog well beyond the some 1500 cycles the frames take
    initial
    begin
        repeat (30000) @(posedge clock_i);
        n_mismatch++;
        give_verdict();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge clock_i);
        #2 rst_i = 1'b0;
        wait_settle();
        chk("reset irq", 4'h1, 4'(irq_n));
        chk("reset drv", 4'h0, {xp, xn, yp, yn});
        t_single_y();
        t_diff_y();
        t_z1();
        t_battery();
        t_temp(`TMC_CH_TEMP_BASE_BIAS_POINT, 1'b0, 21);
        t_temp(`TMC_CH_TEMP_SCALED_BIAS_POINT, 1'b1, 17);
        t_pen();
        give_verdict();
    end
endmodule
